// File: rtl/ajle_pkg.sv
// Package: opcodes, widths and operand-mode types for the jump/AND execution unit
package ajle_pkg;
  localparam int PC_W = 16;
  localparam int PAGE_W = 11;
  localparam logic [4:0] JUMP_LOW = 5'h01;
  localparam logic [7:0] RN_MASK = 8'hF8;
  localparam logic [7:0] IND_MASK = 8'hFE;
  localparam logic [7:0] AND_A_RN = 8'h58;
  localparam logic [7:0] AND_A_DIR = 8'h55;
  localparam logic [7:0] AND_A_IND = 8'h56;
  localparam logic [7:0] AND_A_IMM = 8'h54;
  localparam logic [7:0] AND_DIR_A = 8'h52;
  localparam logic [7:0] AND_DIR_IMM = 8'h53;
  localparam logic [PC_W-1:0] PC_STEP = 16'h0002;
  localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] ADDR_PORT0 = 8'h80;
  localparam logic [7:0] ADDR_PORT1 = 8'h90;
  localparam logic [7:0] ADDR_PORT2 = 8'hA0;
  localparam logic [7:0] ADDR_PORT3 = 8'hB0;

  typedef enum logic [2:0] {
    AJLE_NONE, AJLE_A_RN, AJLE_A_DIR, AJLE_A_IND, AJLE_A_IMM,
    AJLE_DIR_A, AJLE_DIR_IMM, AJLE_JUMP
  } ajle_op_t;

  // One decoded instruction from the fetch stage
  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
    logic [7:0] byte2;
    logic [7:0] byte3;
    logic [PC_W-1:0] pc;
  } ajle_instr_t;

  // Operand values supplied by RAM, register file and port latches
  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] reg_val;
    logic [7:0] ind_val;
    logic [7:0] dir_val;
    logic [7:0] latch_val;
  } ajle_opnd_t;

  // One write or jump produced by the unit
  typedef struct packed {
    logic acc_we;
    logic dir_we;
    logic [7:0] dir_addr;
    logic [7:0] data;
    logic pc_we;
    logic [PC_W-1:0] pc;
    logic busy;
  } ajle_result_t;
endpackage : ajle_pkg

// File: rtl/ajle_exec.sv
// Execution unit for the absolute jump and byte logical AND instructions
// Functional notes
// - Jump target: PC+2 upper five bits, opcode bits 7-5, then second byte.
// - Jump stays in the 2K block after it; upper PC bits never altered.
// - AND combines two bytes bitwise into destination; flags untouched.
// - Six modes: A with Rn/direct/@Ri/#data; direct with A/#data.
// - AND into an output port reads the port output latch, not pins.
// - Direct AND clears bits in any RAM or register by imm or A mask.
`timescale 1ns/1ps
`default_nettype none
module ajle_exec (
  input wire logic i_clk,                       // Core clock
  input wire logic i_reset,                     // Async reset, high
  input wire ajle_pkg::ajle_instr_t i_instr,    // Decoded instruction
  input wire ajle_pkg::ajle_opnd_t i_opnd,      // Operand values
  output ajle_pkg::ajle_result_t o_result       // Registered writes/jump
);
  import ajle_pkg::*;

  // Jump goes first so its low-bit pattern wins over any AND code
  function automatic ajle_op_t decode(input logic [7:0] op);
    if (op[4:0] == JUMP_LOW) return AJLE_JUMP;
    if ((op & RN_MASK) == AND_A_RN) return AJLE_A_RN;
    if ((op & IND_MASK) == AND_A_IND) return AJLE_A_IND;
    unique case (op)
      AND_A_DIR: return AJLE_A_DIR;
      AND_A_IMM: return AJLE_A_IMM;
      AND_DIR_A: return AJLE_DIR_A;
      AND_DIR_IMM: return AJLE_DIR_IMM;
      default: return AJLE_NONE;
    endcase
  endfunction : decode

  // Only the port addresses have a latch distinct from the pins
  function automatic logic is_port(input logic [7:0] a);
    return a == ADDR_PORT0 || a == ADDR_PORT1 ||
           a == ADDR_PORT2 || a == ADDR_PORT3;
  endfunction : is_port

  ajle_result_t res_q, res_d;
  logic jwait_q, jwait_d;
  ajle_op_t op;
  logic [PC_W-1:0] pc_next;
  logic [7:0] dst_orig;

  always_comb begin
    op = decode(i_instr.opcode);
    pc_next = i_instr.pc + PC_STEP;
    // Ports keep pin levels out of read-modify-write
    dst_orig = is_port(i_instr.byte2) ? i_opnd.latch_val : i_opnd.dir_val;
    res_d = '0;
    jwait_d = 1'b0;
    res_d.pc = pc_next;
    if (jwait_q) begin
      // Second machine cycle of the jump holds the core off
      res_d = res_q;
      res_d.busy = 1'b0;
      res_d.pc_we = 1'b0;
    end else if (i_instr.valid) begin
      unique case (op)
        AJLE_JUMP: begin
          res_d.pc = {pc_next[PC_W-1:PAGE_W], i_instr.opcode[7:5],
                      i_instr.byte2};
          res_d.pc_we = 1'b1;
          res_d.busy = 1'b1;
          jwait_d = 1'b1;
        end
        AJLE_A_RN: begin
          res_d.acc_we = 1'b1;
          res_d.data = i_opnd.acc & i_opnd.reg_val;
        end
        AJLE_A_DIR: begin
          res_d.acc_we = 1'b1;
          res_d.data = i_opnd.acc & i_opnd.dir_val;
        end
        AJLE_A_IND: begin
          res_d.acc_we = 1'b1;
          res_d.data = i_opnd.acc & i_opnd.ind_val;
        end
        AJLE_A_IMM: begin
          res_d.acc_we = 1'b1;
          res_d.data = i_opnd.acc & i_instr.byte2;
        end
        AJLE_DIR_A: begin
          res_d.dir_we = 1'b1;
          res_d.dir_addr = i_instr.byte2;
          res_d.data = dst_orig & i_opnd.acc;
        end
        AJLE_DIR_IMM: begin
          res_d.dir_we = 1'b1;
          res_d.dir_addr = i_instr.byte2;
          res_d.data = dst_orig & i_instr.byte3;
        end
        AJLE_NONE: res_d.data = BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      res_q <= '0;
      jwait_q <= 1'b0;
    end else begin
      res_q <= res_d;
      jwait_q <= jwait_d;
    end
  end

  assign o_result = res_q;

  property p_jump_target;
    @(posedge i_clk) disable iff (i_reset)
      (i_instr.valid && !jwait_q && i_instr.opcode[4:0] == JUMP_LOW) |=>
      (res_q.pc_we && res_q.pc[PAGE_W-1:0] ==
       {$past(i_instr.opcode[7:5]), $past(i_instr.byte2)});
  endproperty
  a_jump_target: assert property (p_jump_target)
    else $error("jump target low bits wrong");

  property p_jump_block;
    @(posedge i_clk) disable iff (i_reset)
      res_q.pc_we |-> res_q.pc[PC_W-1:PAGE_W] ==
        ($past(i_instr.pc) + PC_STEP) >> PAGE_W;
  endproperty
  a_jump_block: assert property (p_jump_block)
    else $error("jump left its 2K block");

  property p_jump_two_cycles;
    @(posedge i_clk) disable iff (i_reset)
      $rose(res_q.pc_we) |=> (!res_q.pc_we && !res_q.acc_we &&
        !res_q.dir_we);
  endproperty
  a_jump_two_cycles: assert property (p_jump_two_cycles)
    else $error("jump did not take two cycles");

  property p_and_acc;
    @(posedge i_clk) disable iff (i_reset)
      (i_instr.valid && !jwait_q && i_instr.opcode == AND_A_IMM) |=>
      (res_q.acc_we && res_q.data ==
       ($past(i_opnd.acc) & $past(i_instr.byte2)));
  endproperty
  a_and_acc: assert property (p_and_acc)
    else $error("accumulator AND result wrong");

  property p_and_rn;
    @(posedge i_clk) disable iff (i_reset)
      (i_instr.valid && !jwait_q && (i_instr.opcode & RN_MASK) == AND_A_RN)
      |=> (res_q.acc_we && !res_q.dir_we);
  endproperty
  a_and_rn: assert property (p_and_rn)
    else $error("register AND mode not decoded");

  property p_port_latch;
    @(posedge i_clk) disable iff (i_reset)
      (i_instr.valid && !jwait_q && i_instr.opcode == AND_DIR_IMM &&
       i_instr.byte2 == ADDR_PORT1) |=>
      (res_q.data == ($past(i_opnd.latch_val) & $past(i_instr.byte3)));
  endproperty
  a_port_latch: assert property (p_port_latch)
    else $error("port AND did not use output latch");

  property p_dir_mask;
    @(posedge i_clk) disable iff (i_reset)
      (i_instr.valid && !jwait_q && i_instr.opcode == AND_DIR_A &&
       !is_port(i_instr.byte2)) |=>
      (res_q.dir_we && res_q.dir_addr == $past(i_instr.byte2) &&
       res_q.data == ($past(i_opnd.dir_val) & $past(i_opnd.acc)));
  endproperty
  a_dir_mask: assert property (p_dir_mask)
    else $error("direct AND by accumulator mask wrong");

  property p_one_dest;
    @(posedge i_clk) disable iff (i_reset)
      !(res_q.acc_we && res_q.dir_we) && !(res_q.pc_we && res_q.acc_we);
  endproperty
  a_one_dest: assert property (p_one_dest)
    else $error("more than one destination written");

  property p_rn_data;
    @(posedge i_clk) disable iff (i_reset)
      (i_instr.valid && !jwait_q && (i_instr.opcode & RN_MASK) == AND_A_RN)
      |=> (res_q.data == ($past(i_opnd.acc) & $past(i_opnd.reg_val)));
  endproperty
  a_rn_data: assert property (p_rn_data)
    else $error("register AND result wrong");

  property p_and_ind;
    @(posedge i_clk) disable iff (i_reset)
      (i_instr.valid && !jwait_q &&
       (i_instr.opcode & IND_MASK) == AND_A_IND) |=>
      (res_q.acc_we && res_q.data ==
       ($past(i_opnd.acc) & $past(i_opnd.ind_val)));
  endproperty
  a_and_ind: assert property (p_and_ind)
    else $error("indirect AND result wrong");

  // Accumulator destination reads the direct byte even at a port address
  property p_and_dir;
    @(posedge i_clk) disable iff (i_reset)
      (i_instr.valid && !jwait_q && i_instr.opcode == AND_A_DIR) |=>
      (res_q.acc_we && !res_q.dir_we && res_q.data ==
       ($past(i_opnd.acc) & $past(i_opnd.dir_val)));
  endproperty
  a_and_dir: assert property (p_and_dir)
    else $error("direct source AND result wrong");

  property p_dir_imm;
    @(posedge i_clk) disable iff (i_reset)
      (i_instr.valid && !jwait_q && i_instr.opcode == AND_DIR_IMM &&
       !is_port(i_instr.byte2)) |=>
      (res_q.dir_we && res_q.dir_addr == $past(i_instr.byte2) &&
       res_q.data == ($past(i_opnd.dir_val) & $past(i_instr.byte3)));
  endproperty
  a_dir_imm: assert property (p_dir_imm)
    else $error("direct AND by constant mask wrong");

  // The second machine cycle must neither take input nor move the target
  property p_wait_ignored;
    @(posedge i_clk) disable iff (i_reset)
      jwait_q |=> (!res_q.acc_we && !res_q.dir_we && !res_q.pc_we &&
        !res_q.busy);
  endproperty
  a_wait_ignored: assert property (p_wait_ignored)
    else $error("input taken in jump second cycle");

  property p_wait_pc;
    @(posedge i_clk) disable iff (i_reset)
      jwait_q |=> $stable(res_q.pc);
  endproperty
  a_wait_pc: assert property (p_wait_pc)
    else $error("jump target moved in second cycle");
endmodule : ajle_exec
`default_nettype wire

// File: tb/ajle_opnd_model.sv
// Operand source model: RAM, registers and port latches
`timescale 1ns/1ps
`default_nettype none
module ajle_opnd_model (
  input wire logic [7:0] i_addr, // Direct address
  input wire logic [7:0] i_acc, // Accumulator
  output ajle_pkg::ajle_opnd_t o_opnd // Operand values
);
  import ajle_pkg::*;
  // Pin level and latch differ, so picking the wrong one shows
  always_comb begin
    o_opnd.acc = i_acc;
    o_opnd.reg_val = 8'h55;
    o_opnd.ind_val = 8'h3C;
    o_opnd.dir_val = ~i_addr;
    o_opnd.latch_val = i_addr ^ 8'h5A;
  end
endmodule : ajle_opnd_model
`default_nettype wire

// File: tb/ajle_exec_bench.sv
// Self-checking bench for the jump and logical AND unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module ajle_exec_bench;
  import ajle_pkg::*;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [7:0] acc = 8'hC3;
  ajle_instr_t i_instr = '0;
  ajle_opnd_t i_opnd;
  ajle_result_t o_result;
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;
  always #2.5 i_clk = ~i_clk;
  ajle_opnd_model model (.i_addr(i_instr.byte2), .i_acc(acc),
    .o_opnd(i_opnd));
  ajle_exec dut (.i_clk(i_clk), .i_reset(i_reset), .i_instr(i_instr),
    .i_opnd(i_opnd), .o_result(o_result));
  task automatic test_done();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  // Ceiling is far above the roughly 70 cycles the tests need
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 1000) begin
      n_fail++;
      test_done();
    end
  end
  task automatic issue(input logic [7:0] op, b2, b3,
                       input logic [15:0] pc);
    @(posedge i_clk);
    i_instr <= '{1'b1, op, b2, b3, pc};
    @(posedge i_clk);
    i_instr.valid <= 1'b0;
    #1;
  endtask : issue
  task automatic quiet();
    `CHK({o_result.acc_we, o_result.dir_we}, 2'h0)
    `CHK({o_result.pc_we, o_result.busy}, 2'h0)
  endtask : quiet
  task automatic wr(input logic aw, dw, input logic [7:0] d);
    `CHK({o_result.acc_we, o_result.dir_we}, {aw, dw})
    `CHK(o_result.data, d)
    `CHK(o_result.pc_we, 1'b0)
    if (dw === 1'b1) `CHK(o_result.dir_addr, i_instr.byte2)
  endtask : wr
  task automatic t_and();
    issue(AND_A_RN, 8'h00, 8'h00, '0);
    wr(1, 0, 8'h41);
    issue(AND_A_RN | 8'h07, 8'h00, 8'h00, '0);
    wr(1, 0, 8'h41);
    issue(AND_A_DIR, 8'h30, 8'h00, '0);
    wr(1, 0, 8'hC3 & ~8'h30);
    issue(AND_A_IND, 8'h00, 8'h00, '0);
    wr(1, 0, 8'hC3 & 8'h3C);
    issue(AND_A_IND | 8'h01, 8'h00, 8'h00, '0);
    wr(1, 0, 8'hC3 & 8'h3C);
    issue(AND_A_IMM, 8'h0F, 8'h00, '0);
    wr(1, 0, 8'h03);
    issue(AND_DIR_A, 8'h90, 8'h00, '0);
    wr(0, 1, (8'h90 ^ 8'h5A) & 8'hC3);
    issue(AND_DIR_A, 8'h80, 8'h00, '0);
    wr(0, 1, (8'h80 ^ 8'h5A) & 8'hC3);
    issue(AND_DIR_A, 8'h21, 8'h00, '0);
    wr(0, 1, ~8'h21 & 8'hC3);
    issue(AND_DIR_IMM, 8'hB0, 8'h73, '0);
    wr(0, 1, (8'hB0 ^ 8'h5A) & 8'h73);
    issue(AND_DIR_IMM, 8'h90, 8'h73, '0);
    wr(0, 1, (8'h90 ^ 8'h5A) & 8'h73);
    issue(AND_DIR_IMM, 8'hA0, 8'h73, '0);
    wr(0, 1, (8'hA0 ^ 8'h5A) & 8'h73);
    issue(AND_DIR_IMM, 8'h30, 8'h73, '0);
    wr(0, 1, ~8'h30 & 8'h73);
    $display("test and done");
  endtask : t_and
  task automatic t_jump();
    for (int k = 0; k < 8; k++) begin
      issue({k[2:0], JUMP_LOW}, 8'hA5, 8'h00, 16'h07FE);
      `CHK({o_result.pc_we, o_result.busy}, 2'h3)
      `CHK(o_result.pc, {5'h01, k[2:0], 8'hA5})
      `CHK(o_result.acc_we | o_result.dir_we, 1'b0)
      @(posedge i_clk);
      #1;
      quiet();
    end
    issue(8'h21, 8'h23, 8'h00, 16'h0345);
    `CHK(o_result.pc, 16'h0123)
    issue(8'hE1, 8'hFF, 8'h00, 16'hF345);
    `CHK(o_result.pc, 16'hF7FF)
    $display("test jump done");
  endtask : t_jump
  // An AND offered in the jump's second cycle must be dropped
  task automatic t_wait();
    @(posedge i_clk);
    i_instr <= '{1'b1, 8'h01, 8'h10, 8'h00, 16'h1000};
    @(posedge i_clk);
    i_instr <= '{1'b1, AND_A_IMM, 8'h0F, 8'h00, 16'h0000};
    #1;
    `CHK({o_result.pc_we, o_result.busy}, 2'h3)
    `CHK(o_result.pc, 16'h1010)
    @(posedge i_clk);
    i_instr.valid <= 1'b0;
    #1;
    quiet();
    @(posedge i_clk);
    #1;
    quiet();
    $display("test wait done");
  endtask : t_wait
  task automatic t_reset();
    issue(8'h41, 8'h77, 8'h00, 16'h2000);
    `CHK(o_result.pc_we, 1'b1)
    `CHK(o_result.pc, 16'h2277)
    @(posedge i_clk);
    i_reset <= 1'b1;
    #1;
    quiet();
    @(posedge i_clk);
    i_reset <= 1'b0;
    #1;
    quiet();
    issue(AND_A_IMM, 8'hF0, 8'h00, '0);
    wr(1, 0, 8'hC0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_bad();
    issue(8'hA5, 8'h30, 8'h00, '0);
    quiet();
    $display("test bad done");
  endtask : t_bad
  initial begin
    repeat (5) @(posedge i_clk);
    i_reset <= 1'b0;
    #1;
    quiet();
    t_and();
    t_jump();
    t_wait();
    t_reset();
    t_bad();
    test_done();
  end
endmodule : ajle_exec_bench
`default_nettype wire
